/* inc/hra_pkg.sv */
// Constants shared by the host register access block.
package hra_pkg;
	// Host I/O ports, dword-aligned addresses
	localparam logic [15:0] IO_CFG_ADDR_PORT = 16'h0CF8;
	localparam logic [15:0] IO_CFG_DATA_PORT = 16'h0CFC;
	// Configuration address register layout
	localparam int CA_ENABLE_BIT = 31;
	localparam int CA_BUS_LSB = 16;
	localparam int CA_DEV_LSB = 11;
	localparam int CA_FUNC_LSB = 8;
	localparam int CA_IDX_LSB = 2;
	localparam logic [31:0] CA_WRITE_MASK = 32'h80FFFFFC;
	localparam logic [31:0] CA_RESET = 32'h00000000;
	// Internal register dword indices
	localparam logic [5:0] IDX_IDENT = 6'h00;
	localparam logic [5:0] IDX_CTRL = 6'h01;
	localparam logic [5:0] IDX_STATUS = 6'h02;
	localparam logic [5:0] IDX_ONCE = 6'h03;
	localparam logic [5:0] IDX_LOCK = 6'h04;
	localparam logic [5:0] IDX_STRAP = 6'h05;
	localparam logic [5:0] IDX_SPLIT = 6'h06;
	localparam logic [5:0] IDX_WONLY = 6'h07;
	// Identity value, arbitrary
	localparam logic [31:0] IDENT_VALUE = 32'h5A5A0001;
	// Reset defaults
	localparam logic [31:0] CTRL_RESET = 32'h00000001;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [31:0] ONCE_RESET = 32'h00000000;
	localparam logic [31:0] LOCK_RESET = 32'h00000000;
	localparam int LOCK_BIT = 31;
	localparam logic [31:0] SPLIT_RESET = 32'h00000000;
	localparam logic [31:0] WONLY_RESET = 32'h00000000;
	localparam logic [7:0] STRAP_SYNC_RESET = 8'h00;
	// Read answers
	localparam logic [31:0] RSVD_READ = 32'hDEADBEEF;
	localparam logic [31:0] NO_TARGET_READ = 32'hFFFFFFFF;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
endpackage

/* src/hra_host_regs.sv */
// Host I/O access layer with configuration mechanism and attribute registers.
`timescale 1ns/1ps
module hra_host_regs (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic io_valid_in,
	input wire logic io_write_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [3:0] io_be_in,
	input wire logic [31:0] io_wdata_in,
	input wire logic [7:0] event_in,
	input wire logic [7:0] strap_in,
	output logic io_ack_out,
	output logic [31:0] io_rdata_out,
	output logic cfg_cycle_out,
	output logic [31:0] ctrl_out,
	output logic [31:0] command_out
);
	logic [31:0] cfg_addr_ff;
	logic [31:0] ctrl_ff;
	logic [7:0] status_ff;
	logic [31:0] once_ff;
	logic [3:0] once_done_ff;
	logic [31:0] lock_ff;
	logic [31:0] strap_reg_ff;
	logic [31:0] split_wr_ff;
	logic [31:0] split_rd_ff;
	logic [31:0] wonly_ff;
	logic [7:0] strap_meta_ff;
	logic [7:0] strap_sync_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] lane_mask;
	logic addr_hit, data_hit, cfg_en, cfg_target, cfg_wr, cfg_rd;
	logic [5:0] cfg_idx;

	// Byte enable i covers bits 8i+7..8i
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{io_be_in[i]}};
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk,
		input logic [31:0] wd);
		merge = (old & ~msk) | (wd & msk);
	endfunction

	// Port decode
	assign addr_hit = io_valid_in && (io_addr_in == hra_pkg::IO_CFG_ADDR_PORT);
	assign data_hit = io_valid_in && (io_addr_in == hra_pkg::IO_CFG_DATA_PORT);
	assign cfg_en = cfg_addr_ff[hra_pkg::CA_ENABLE_BIT];
	assign cfg_target = (cfg_addr_ff[hra_pkg::CA_BUS_LSB +: 8] == 8'h00)
		&& (cfg_addr_ff[hra_pkg::CA_DEV_LSB +: 5] == 5'h00)
		&& (cfg_addr_ff[hra_pkg::CA_FUNC_LSB +: 3] == 3'h0);
	assign cfg_idx = cfg_addr_ff[hra_pkg::CA_IDX_LSB +: 6];
	assign cfg_wr = data_hit && io_write_in && cfg_en && cfg_target;
	assign cfg_rd = data_hit && !io_write_in && cfg_en && cfg_target;
	assign ctrl_out = ctrl_ff;
	assign command_out = split_wr_ff;

	// Strap synchroniser
	always_ff @(posedge clk_in) begin
		strap_meta_ff <= strap_in;
		strap_sync_ff <= strap_meta_ff;
	end

	// Configuration address register, dword writes only
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cfg_addr_ff <= hra_pkg::CA_RESET;
		end else if (addr_hit && io_write_in && io_be_in == 4'hF) begin
			cfg_addr_ff <= io_wdata_in & hra_pkg::CA_WRITE_MASK;
		end
	end

	// Read/write control register
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ctrl_ff <= hra_pkg::CTRL_RESET;
		end else if (cfg_wr && cfg_idx == hra_pkg::IDX_CTRL) begin
			ctrl_ff <= merge(ctrl_ff, lane_mask, io_wdata_in);
		end
	end

	// Sticky status, set wins over clear
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			status_ff <= hra_pkg::STATUS_RESET;
		end else if (cfg_wr && cfg_idx == hra_pkg::IDX_STATUS) begin
			status_ff <= (status_ff & ~(io_wdata_in[7:0] & lane_mask[7:0])) | event_in;
		end else begin
			status_ff <= status_ff | event_in;
		end
	end

	// Write-once bytes
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			once_ff <= hra_pkg::ONCE_RESET;
			once_done_ff <= 4'h0;
		end else if (cfg_wr && cfg_idx == hra_pkg::IDX_ONCE) begin
			for (int i = 0; i < 4; i++) begin
				if (io_be_in[i] && !once_done_ff[i]) begin
					once_ff[i*8 +: 8] <= io_wdata_in[i*8 +: 8];
					once_done_ff[i] <= 1'b1;
				end
			end
		end
	end

	// Lockable register, lock bit sticky until reset
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			lock_ff <= hra_pkg::LOCK_RESET;
		end else if (cfg_wr && cfg_idx == hra_pkg::IDX_LOCK && !lock_ff[hra_pkg::LOCK_BIT]) begin
			lock_ff <= merge(lock_ff, lane_mask, io_wdata_in);
		end
	end

	// Strap-defaulted register
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			strap_reg_ff <= {24'h000000, strap_sync_ff};
		end else if (cfg_wr && cfg_idx == hra_pkg::IDX_STRAP) begin
			strap_reg_ff <= merge(strap_reg_ff, lane_mask, io_wdata_in);
		end
	end

	// Shared location: writes command, reads count writes
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			split_wr_ff <= hra_pkg::SPLIT_RESET;
			split_rd_ff <= hra_pkg::SPLIT_RESET;
		end else if (cfg_wr && cfg_idx == hra_pkg::IDX_SPLIT) begin
			split_wr_ff <= merge(split_wr_ff, lane_mask, io_wdata_in);
			split_rd_ff <= split_rd_ff + 32'h00000001;
		end
	end

	// Write-only register, reads leave it alone
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wonly_ff <= hra_pkg::WONLY_RESET;
		end else if (cfg_wr && cfg_idx == hra_pkg::IDX_WONLY) begin
			wonly_ff <= merge(wonly_ff, lane_mask, io_wdata_in);
		end
	end

	// Read mux
	always_comb begin
		nxt_rdata = hra_pkg::NO_TARGET_READ;
		if (addr_hit) begin
			nxt_rdata = cfg_addr_ff;
		end else if (cfg_rd) begin
			case (cfg_idx)
				hra_pkg::IDX_IDENT: nxt_rdata = hra_pkg::IDENT_VALUE;
				hra_pkg::IDX_CTRL: nxt_rdata = ctrl_ff;
				hra_pkg::IDX_STATUS: nxt_rdata = {24'h000000, status_ff};
				hra_pkg::IDX_ONCE: nxt_rdata = once_ff;
				hra_pkg::IDX_LOCK: nxt_rdata = lock_ff;
				hra_pkg::IDX_STRAP: nxt_rdata = strap_reg_ff;
				hra_pkg::IDX_SPLIT: nxt_rdata = split_rd_ff;
				hra_pkg::IDX_WONLY: nxt_rdata = hra_pkg::ZERO_WORD;
				default: nxt_rdata = hra_pkg::RSVD_READ;
			endcase
		end
	end

	// Answer one cycle after the request
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			io_ack_out <= 1'b0;
			io_rdata_out <= hra_pkg::ZERO_WORD;
			cfg_cycle_out <= 1'b0;
		end else begin
			io_ack_out <= io_valid_in;
			io_rdata_out <= (io_valid_in && !io_write_in) ? nxt_rdata : hra_pkg::ZERO_WORD;
			cfg_cycle_out <= data_hit && cfg_en;
		end
	end

	a_ack_timing: assert property (@(posedge clk_in) disable iff (reset_in)
		io_valid_in |=> io_ack_out) else $error("Missing ack");
	a_addr_partial: assert property (@(posedge clk_in) disable iff (reset_in)
		addr_hit && io_write_in && io_be_in != 4'hF |=> $stable(cfg_addr_ff))
		else $error("Partial address write took effect");
	a_cfg_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		data_hit && !cfg_en && !io_write_in |=> cfg_cycle_out == 1'b0
		&& io_rdata_out == hra_pkg::NO_TARGET_READ) else $error("Disabled cycle ran");
	a_ctrl_readback: assert property (@(posedge clk_in) disable iff (reset_in)
		cfg_wr && cfg_idx == hra_pkg::IDX_CTRL && io_be_in == 4'hF
		|=> ctrl_ff == $past(io_wdata_in)) else $error("Control readback wrong");
	a_status_clear: assert property (@(posedge clk_in) disable iff (reset_in)
		cfg_wr && cfg_idx == hra_pkg::IDX_STATUS && io_be_in[0] && io_wdata_in[0]
		&& !event_in[0] |=> !status_ff[0]) else $error("Status bit not cleared");
	a_once_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		once_done_ff == 4'hF |=> $stable(once_ff)) else $error("Write-once changed");
	a_lock_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		lock_ff[hra_pkg::LOCK_BIT] |=> $stable(lock_ff)) else $error("Locked bits changed");
	a_ident_const: assert property (@(posedge clk_in) disable iff (reset_in)
		cfg_rd && cfg_idx == hra_pkg::IDX_IDENT |=> io_rdata_out == hra_pkg::IDENT_VALUE)
		else $error("Read-only value wrong");
	a_wonly_read: assert property (@(posedge clk_in) disable iff (reset_in)
		cfg_rd && cfg_idx == hra_pkg::IDX_WONLY |=> $stable(wonly_ff))
		else $error("Read changed write-only");
	a_strap_load: assert property (@(posedge clk_in)
		$past(reset_in) && !reset_in |-> strap_reg_ff[7:0] == $past(strap_sync_ff))
		else $error("Strap default wrong");
endmodule

/* tb/hra_host_model.sv */
// Host processor model issuing one I/O access at a time
`timescale 1ns/1ps
module hra_host_model (
	input wire logic clk_in,
	input wire logic io_ack_in,
	input wire logic [31:0] io_rdata_in,
	output logic io_valid_out,
	output logic io_write_out,
	output logic [15:0] io_addr_out,
	output logic [3:0] io_be_out,
	output logic [31:0] io_wdata_out
);
	logic timed_out = 1'b0;
	initial begin
		io_valid_out = 1'b0;
		io_write_out = 1'b0;
		io_addr_out = 16'h0000;
		io_be_out = 4'h0;
		io_wdata_out = 32'h00000000;
	end
	// Address port dword only callers merge reserved bits
	task automatic io(input logic w, input logic [15:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_in);
		io_valid_out <= 1'b1;
		io_write_out <= w;
		io_addr_out <= a;
		io_be_out <= b;
		io_wdata_out <= d;
		@(posedge clk_in);
		io_valid_out <= 1'b0;
		io_addr_out <= ~a;
		io_be_out <= ~b;
		io_wdata_out <= ~d;
		n = 0;
		@(negedge clk_in);
		while (io_ack_in !== 1'b1 && n < 4) begin
			@(negedge clk_in);
			n++;
		end
		if (n == 4) timed_out = 1'b1;
		q = io_rdata_in;
	endtask
endmodule

/* tb/host_register_access_rules_tb.sv */
// Self-checking testbench for the host register access block
`timescale 1ns/1ps
module host_register_access_rules_tb;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] event_in = 8'h00;
	logic [7:0] strap_in = 8'hA5;
	logic vld, wr_en, ack, cfg;
	logic [15:0] addr;
	logic [3:0] be;
	logic [31:0] wdat, rdat, ctrl, cmd, q;
	int n_errors = 0;
	int tests_run = 0;
	always #12.5 clk_in = ~clk_in;
	hra_host_regs uut (.clk_in(clk_in), .reset_in(reset_in), .io_valid_in(vld),
		.io_write_in(wr_en), .io_addr_in(addr), .io_be_in(be), .io_wdata_in(wdat),
		.event_in(event_in), .strap_in(strap_in), .io_ack_out(ack), .io_rdata_out(rdat),
		.cfg_cycle_out(cfg), .ctrl_out(ctrl), .command_out(cmd));
	hra_host_model host (.clk_in(clk_in), .io_ack_in(ack), .io_rdata_in(rdat),
		.io_valid_out(vld), .io_write_out(wr_en), .io_addr_out(addr), .io_be_out(be),
		.io_wdata_out(wdat));
	task automatic results();
		$display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b,
		input logic [31:0] d);
		host.io(w, a, b, d, q);
		if (host.timed_out) begin
			n_errors++;
			results();
		end
	endtask
	task automatic wr(input logic [5:0] i, input logic [3:0] b, input logic [31:0] d);
		acc(1'b1, hra_pkg::IO_CFG_ADDR_PORT, 4'hF, {1'b1, 23'h0, i, 2'b00});
		acc(1'b1, hra_pkg::IO_CFG_DATA_PORT, b, d);
	endtask
	task automatic rd(input logic [5:0] i);
		acc(1'b1, hra_pkg::IO_CFG_ADDR_PORT, 4'hF, {1'b1, 23'h0, i, 2'b00});
		acc(1'b0, hra_pkg::IO_CFG_DATA_PORT, 4'hF, 32'h00000000);
	endtask
	task automatic t_reset();
		@(negedge clk_in);
		chk("ctrl", hra_pkg::CTRL_RESET, ctrl);
		rd(hra_pkg::IDX_STRAP);
		chk("strap", {24'h0, 8'hA5}, q);
		wr(hra_pkg::IDX_IDENT, 4'hF, 32'h00000000);
		rd(hra_pkg::IDX_IDENT);
		chk("ident", hra_pkg::IDENT_VALUE, q);
		rd(6'h20);
		chk("rsvd", hra_pkg::RSVD_READ, q);
		$display("test reset done");
	endtask
	task automatic t_addr();
		acc(1'b1, hra_pkg::IO_CFG_ADDR_PORT, 4'hF, 32'hFFFFFFFF);
		acc(1'b1, hra_pkg::IO_CFG_ADDR_PORT, 4'h3, 32'h00000000);
		acc(1'b0, hra_pkg::IO_CFG_ADDR_PORT, 4'hF, 32'h00000000);
		chk("addr", hra_pkg::CA_WRITE_MASK, q);
		acc(1'b1, hra_pkg::IO_CFG_ADDR_PORT, 4'hF, 32'h00000004);
		acc(1'b0, hra_pkg::IO_CFG_DATA_PORT, 4'hF, 32'h00000000);
		chk("off read", hra_pkg::NO_TARGET_READ, q);
		chk("off cfg", 32'h0, {31'h0, cfg});
		rd(hra_pkg::IDX_CTRL);
		chk("on cfg", 32'h1, {31'h0, cfg});
		$display("test address done");
	endtask
	task automatic t_rw();
		wr(hra_pkg::IDX_CTRL, 4'hF, 32'h11223344);
		wr(hra_pkg::IDX_CTRL, 4'h2, 32'hAABBCCDD);
		chk("ctrl out", 32'h1122CC44, ctrl);
		rd(hra_pkg::IDX_CTRL);
		chk("ctrl", 32'h1122CC44, q);
		wr(hra_pkg::IDX_CTRL, 4'hF, (q & 32'hFFFFFF00) | 32'h00000099);
		rd(hra_pkg::IDX_CTRL);
		chk("ctrl merge", 32'h1122CC99, q);
		@(posedge clk_in) event_in <= 8'h0F;
		@(posedge clk_in) event_in <= 8'h00;
		wr(hra_pkg::IDX_STATUS, 4'h1, 32'h00000003);
		wr(hra_pkg::IDX_STATUS, 4'h1, 32'h00000000);
		rd(hra_pkg::IDX_STATUS);
		chk("status", 32'h0000000C, q);
		$display("test read write done");
	endtask
	task automatic t_once_lock();
		wr(hra_pkg::IDX_ONCE, 4'h1, 32'h00000078);
		wr(hra_pkg::IDX_ONCE, 4'hF, 32'hAABBCCDD);
		wr(hra_pkg::IDX_ONCE, 4'hF, 32'h00000000);
		rd(hra_pkg::IDX_ONCE);
		chk("once", 32'hAABBCC78, q);
		wr(hra_pkg::IDX_LOCK, 4'hF, 32'h000000FF);
		wr(hra_pkg::IDX_LOCK, 4'hF, 32'h80000055);
		wr(hra_pkg::IDX_LOCK, 4'hF, 32'h00000000);
		rd(hra_pkg::IDX_LOCK);
		chk("lock", 32'h80000055, q);
		$display("test once lock done");
	endtask
	task automatic t_split();
		wr(hra_pkg::IDX_SPLIT, 4'hF, 32'hCAFEF00D);
		chk("command", 32'hCAFEF00D, cmd);
		wr(hra_pkg::IDX_SPLIT, 4'hF, 32'h00000001);
		rd(hra_pkg::IDX_SPLIT);
		rd(hra_pkg::IDX_SPLIT);
		chk("count", 32'h00000002, q);
		rd(hra_pkg::IDX_WONLY);
		chk("wonly", hra_pkg::ZERO_WORD, q);
		chk("command", 32'h00000001, cmd);
		$display("test split done");
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		t_reset();
		t_addr();
		t_rw();
		t_once_lock();
		t_split();
		results();
	end
endmodule
